// ---- logic/lane_if.sv ----
// raw and filtered pin levels between the sampler and the port logic
interface lane_if;
  import spi_port_pkg::*;
  logic [PIN_COUNT-1:0] raw;
  logic [PIN_COUNT-1:0] level;
  modport source (input raw, output level);
  modport sink   (output raw, input level);
endinterface

// ---- logic/page_memory_serial_port.sv ----
// serial interface front end of a page memory: framing, hold, lane turnaround, protect pin
module page_memory_serial_port
  import spi_port_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  output logic            serial_out_lane1_o,
  output logic            serial_out_lane1_oe,
  input  wire logic       serial_in_lane0_i,
  output logic            serial_in_lane0_o,
  output logic            serial_in_lane0_oe,
  input  wire logic       protect_pin_lane2_i,
  output logic            protect_pin_lane2_o,
  output logic            protect_pin_lane2_oe,
  input  wire logic       pause_pin_lane3_i,
  output logic            pause_pin_lane3_o,
  output logic            pause_pin_lane3_oe,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_first,
  output logic            cmd_start,
  output logic            cmd_end,
  output logic            cmd_exec,
  output logic            iface_reset,
  input  wire logic       read_cmd,
  input  wire read_mode_t read_mode,
  input  wire logic [7:0] tx_byte,
  output logic            tx_req,
  input  wire logic       write_in_progress,
  input  wire logic       srwd,
  input  wire logic       bp_wr_en,
  input  wire logic [2:0] bp_wr_data,
  input  wire logic       tb_wr_data,
  output logic [2:0]      block_protect_bits,
  output logic            top_bottom_select,
  output logic            protect_lock,
  output logic            standby,
  output logic            active_power,
  output logic            paused
);

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  lane_if pins ();

  assign pins.raw[PIN_SCLK]  = sclk;
  assign pins.raw[PIN_CS]    = cs_n;
  assign pins.raw[PIN_LANE0] = serial_in_lane0_i;
  assign pins.raw[PIN_LANE2] = protect_pin_lane2_i;
  assign pins.raw[PIN_LANE3] = pause_pin_lane3_i;

  pin_sync u_pin_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pins    (pins)
  );

  logic sclk_l;
  logic cs_l;
  logic lane0_l;
  logic lane2_l;
  logic lane3_l;

  assign sclk_l  = pins.level[PIN_SCLK];
  assign cs_l    = pins.level[PIN_CS];
  assign lane0_l = pins.level[PIN_LANE0];
  assign lane2_l = pins.level[PIN_LANE2];
  assign lane3_l = pins.level[PIN_LANE3];

  // ****************************************************************
  // edge detection
  // ****************************************************************
  logic       sclk_prev_reg;
  logic       cs_prev_reg;
  logic [2:0] settle_reg;
  logic       seen_high_reg;
  logic       settled;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;

  // either idle clock level works: shifting uses only edges, though pause waits for a low clock level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_reg <= PIN_RESET[PIN_SCLK];
      cs_prev_reg   <= PIN_RESET[PIN_CS];
    end else begin
      sclk_prev_reg <= sclk_l;
      cs_prev_reg   <= cs_l;
    end
  end

  // a select held low through reset is not taken as a falling edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg    <= SETTLE_RESET;
      seen_high_reg <= 1'b0;
    end else begin
      if (!settled) begin
        settle_reg <= settle_reg + 3'h1;
      end
      if (settled && cs_l) begin
        seen_high_reg <= 1'b1;
      end
    end
  end

  assign settled   = (settle_reg == SETTLE_CYCLES);
  assign sclk_rise = sclk_l && !sclk_prev_reg;
  assign sclk_fall = !sclk_l && sclk_prev_reg;
  assign cs_fall   = !cs_l && cs_prev_reg;
  assign cs_rise   = cs_l && !cs_prev_reg;

  // ****************************************************************
  // link state
  // ****************************************************************
  link_state_t state_reg;
  logic        quad_dir_reg;
  logic        pause_enter;
  logic        pause_leave;
  logic        rise_ok;
  logic        fall_ok;

  // hold needs select low, only reachable from the active state
  // pause starts once the clock is low, so a high clock defers it
  assign pause_enter = !quad_dir_reg && !lane3_l && !sclk_l;
  // release while clock low leaves at once, else at the next low clock
  assign pause_leave = lane3_l && !sclk_l;
  // edges count only while selected and not paused
  assign rise_ok     = (state_reg == LINK_ACTIVE) && sclk_rise && !cs_rise;
  assign fall_ok     = (state_reg == LINK_ACTIVE) && sclk_fall && !cs_rise;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LINK_OFF;
    end else begin
      case (state_reg)
        LINK_OFF: begin
          if (cs_fall && seen_high_reg) begin
            state_reg <= LINK_ACTIVE;
          end
        end
        LINK_IDLE: begin
          if (cs_fall) begin
            state_reg <= LINK_ACTIVE;
          end
        end
        LINK_ACTIVE: begin
          if (cs_rise) begin
            state_reg <= LINK_IDLE;
          end else if (pause_enter) begin
            state_reg <= LINK_PAUSED;
          end
        end
        LINK_PAUSED: begin
          if (cs_rise) begin
            state_reg <= LINK_IDLE;
          end else if (pause_leave) begin
            state_reg <= LINK_ACTIVE;
          end
        end
        default: begin
          state_reg <= LINK_OFF;
        end
      endcase
    end
  end

  // ****************************************************************
  // frame events
  // ****************************************************************
  logic cmd_start_reg;
  logic cmd_end_reg;
  logic cmd_exec_reg;
  logic iface_reset_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_start_reg   <= 1'b0;
      cmd_end_reg     <= 1'b0;
      cmd_exec_reg    <= 1'b0;
      iface_reset_reg <= 1'b0;
    end else begin
      cmd_start_reg   <= cs_fall && (state_reg == LINK_IDLE || (state_reg == LINK_OFF && seen_high_reg));
      cmd_end_reg     <= cs_rise && (state_reg == LINK_ACTIVE || state_reg == LINK_PAUSED);
      cmd_exec_reg    <= cs_rise && (state_reg == LINK_ACTIVE) && (bit_cnt_reg == BIT_FIRST)
                         && (byte_cnt_reg != BYTE_FIRST);
      // latch and write flags live outside and are left alone
      iface_reset_reg <= cs_rise && (state_reg == LINK_PAUSED);
    end
  end

  // ****************************************************************
  // receive path
  // ****************************************************************
  logic [7:0] shift_in_reg;
  logic [7:0] rx_byte_reg;
  logic       rx_valid_reg;
  logic       rx_first_reg;
  logic [7:0] shift_in_next;

  assign shift_in_next = {shift_in_reg[6:0], lane0_l};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg  <= BIT_FIRST;
      byte_cnt_reg <= BYTE_FIRST;
      shift_in_reg <= BYTE_RESET;
      rx_byte_reg  <= BYTE_RESET;
      rx_valid_reg <= 1'b0;
      rx_first_reg <= 1'b0;
      quad_dir_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (cs_fall || cs_rise) begin
        bit_cnt_reg  <= BIT_FIRST;
        byte_cnt_reg <= BYTE_FIRST;
        quad_dir_reg <= 1'b0;
      end else if (rise_ok) begin
        // first rising edge after select fall is bit zero
        shift_in_reg <= shift_in_next;
        bit_cnt_reg  <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == BIT_LAST) begin
          rx_byte_reg  <= shift_in_next;
          rx_valid_reg <= 1'b1;
          rx_first_reg <= (byte_cnt_reg == BYTE_FIRST);
          if (byte_cnt_reg != BYTE_CNT_MAX) begin
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
          end
          if (byte_cnt_reg == ADDR_LAST_BYTE && read_mode == READ_QUAD) begin
            quad_dir_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // transmit path
  // ****************************************************************
  function automatic logic [3:0] place(input read_mode_t m, input logic [3:0] t);
    case (m)
      READ_DUAL: place = {2'b00, t[3], t[2]};
      READ_QUAD: place = t;
      default:   place = {2'b00, t[3], 1'b0};
    endcase
  endfunction

  function automatic logic [7:0] advance(input read_mode_t m, input logic [7:0] b);
    case (m)
      READ_DUAL: advance = {b[5:0], 2'b00};
      READ_QUAD: advance = {b[3:0], 4'h0};
      default:   advance = {b[6:0], 1'b0};
    endcase
  endfunction

  function automatic logic [2:0] groups(input read_mode_t m);
    case (m)
      READ_DUAL: groups = SHIFTS_DUAL;
      READ_QUAD: groups = SHIFTS_QUAD;
      default:   groups = SHIFTS_SINGLE;
    endcase
  endfunction

  logic       tx_active_reg;
  read_mode_t tx_mode_reg;
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_left_reg;
  logic [3:0] lanes_reg;
  logic       tx_req_reg;
  logic       tx_start;
  read_mode_t load_mode;

  // read starts on a byte boundary once the instruction byte is in
  assign tx_start  = !tx_active_reg && read_cmd && (byte_cnt_reg != BYTE_FIRST) && (bit_cnt_reg == BIT_FIRST);
  assign load_mode = tx_active_reg ? tx_mode_reg : read_mode;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_active_reg <= 1'b0;
      tx_mode_reg   <= READ_SINGLE;
      tx_shift_reg  <= BYTE_RESET;
      tx_left_reg   <= SHIFTS_NONE;
      lanes_reg     <= LANES_RESET;
      tx_req_reg    <= 1'b0;
    end else begin
      tx_req_reg <= 1'b0;
      if (cs_fall || cs_rise) begin
        tx_active_reg <= 1'b0;
        tx_left_reg   <= SHIFTS_NONE;
        lanes_reg     <= LANES_RESET;
      end else if (fall_ok && (tx_active_reg || tx_start)) begin
        // lanes move only on a falling edge, and clear on either select edge
        if (!tx_active_reg || tx_left_reg == SHIFTS_NONE) begin
          tx_active_reg <= 1'b1;
          tx_mode_reg   <= load_mode;
          lanes_reg     <= place(load_mode, tx_byte[7:4]);
          tx_shift_reg  <= advance(load_mode, tx_byte);
          tx_left_reg   <= groups(load_mode);
          tx_req_reg    <= 1'b1;
        end else begin
          lanes_reg    <= place(tx_mode_reg, tx_shift_reg[7:4]);
          tx_shift_reg <= advance(tx_mode_reg, tx_shift_reg);
          tx_left_reg  <= tx_left_reg - 3'h1;
        end
      end
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  logic driving;

  // floats when deselected or paused
  assign driving              = (state_reg == LINK_ACTIVE) && !cs_l;
  assign serial_out_lane1_o   = lanes_reg[1];
  assign serial_out_lane1_oe  = driving && tx_active_reg;
  assign serial_in_lane0_o    = lanes_reg[0];
  // single reads leave lanes zero, two, three as inputs
  assign serial_in_lane0_oe   = driving && tx_active_reg && (tx_mode_reg != READ_SINGLE);
  assign protect_pin_lane2_o  = lanes_reg[2];
  assign protect_pin_lane2_oe = driving && quad_dir_reg;
  assign pause_pin_lane3_o    = lanes_reg[3];
  assign pause_pin_lane3_oe   = driving && quad_dir_reg;

  // ****************************************************************
  // protection bits and power mode
  // ****************************************************************
  logic [2:0] bp_reg;
  logic       tb_reg;
  logic       lock;
  logic       standby_reg;
  logic       active_reg;

  // protect pin level is trusted only while the master drives it, not after quad turnaround
  assign lock = srwd && !lane2_l && !quad_dir_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bp_reg <= BP_RESET;
      tb_reg <= TB_RESET;
    end else if (bp_wr_en && !lock) begin
      bp_reg <= bp_wr_data;
      tb_reg <= tb_wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      standby_reg <= 1'b1;
      active_reg  <= 1'b0;
    end else begin
      standby_reg <= (state_reg == LINK_OFF || state_reg == LINK_IDLE) && !write_in_progress;
      active_reg  <= (state_reg == LINK_ACTIVE || state_reg == LINK_PAUSED) || write_in_progress;
    end
  end

  assign rx_byte            = rx_byte_reg;
  assign rx_valid           = rx_valid_reg;
  assign rx_first           = rx_first_reg;
  assign cmd_start          = cmd_start_reg;
  assign cmd_end            = cmd_end_reg;
  assign cmd_exec           = cmd_exec_reg;
  assign iface_reset        = iface_reset_reg;
  assign tx_req             = tx_req_reg;
  assign block_protect_bits = bp_reg;
  assign top_bottom_select  = tb_reg;
  assign protect_lock       = lock;
  assign standby            = standby_reg;
  assign active_power       = active_reg;
  assign paused             = (state_reg == LINK_PAUSED);

endmodule

// ---- logic/pin_sync.sv ----
// three stage sampler for the link pins, change taken once the last two stages agree
module pin_sync
  import spi_port_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  lane_if.source    pins
);

  logic [PIN_COUNT-1:0] stage1_reg;
  logic [PIN_COUNT-1:0] stage2_reg;
  logic [PIN_COUNT-1:0] stage3_reg;
  logic [PIN_COUNT-1:0] level_reg;

  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stage1_reg[i] <= PIN_RESET[i];
          stage2_reg[i] <= PIN_RESET[i];
          stage3_reg[i] <= PIN_RESET[i];
          level_reg[i]  <= PIN_RESET[i];
        end else begin
          stage1_reg[i] <= pins.raw[i];
          stage2_reg[i] <= stage1_reg[i];
          stage3_reg[i] <= stage2_reg[i];
          if (stage2_reg[i] == stage3_reg[i]) begin
            level_reg[i] <= stage3_reg[i];
          end
        end
      end
    end
  endgenerate

  assign pins.level = level_reg;

endmodule

// ---- logic/spi_port_pkg.sv ----
// constants and types shared by the serial port front end
package spi_port_pkg;

  // ****************************************************************
  // pin vector layout
  // ****************************************************************
  localparam int         PIN_COUNT   = 5;
  localparam int         PIN_SCLK    = 0;
  localparam int         PIN_CS      = 1;
  localparam int         PIN_LANE0   = 2;
  localparam int         PIN_LANE2   = 3;
  localparam int         PIN_LANE3   = 4;
  // select and pause idle high, the rest low
  localparam logic [4:0] PIN_RESET   = 5'h12;

  // ****************************************************************
  // counts and reset values
  // ****************************************************************
  localparam logic [2:0] SETTLE_CYCLES  = 3'h4;
  localparam logic [2:0] SETTLE_RESET   = 3'h0;
  localparam logic [2:0] BIT_FIRST      = 3'h0;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BYTE_FIRST     = 3'h0;
  localparam logic [2:0] BYTE_CNT_MAX   = 3'h7;
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic [3:0] LANES_RESET    = 4'h0;
  localparam logic [2:0] BP_RESET       = 3'h0;
  localparam logic       TB_RESET       = 1'b0;
  // falling edges left in a byte after its first lane group
  localparam logic [2:0] SHIFTS_SINGLE  = 3'h7;
  localparam logic [2:0] SHIFTS_DUAL    = 3'h3;
  localparam logic [2:0] SHIFTS_QUAD    = 3'h1;
  localparam logic [2:0] SHIFTS_NONE    = 3'h0;

  // ****************************************************************
  // enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    READ_SINGLE = 2'h0,
    READ_DUAL   = 2'h1,
    READ_QUAD   = 2'h2
  } read_mode_t;

  typedef enum logic [1:0] {
    LINK_OFF    = 2'h0,
    LINK_IDLE   = 2'h1,
    LINK_ACTIVE = 2'h3,
    LINK_PAUSED = 2'h2
  } link_state_t;

endpackage

// ---- testbench/page_memory_serial_port_monitor.sv ----
// assertions on the pins and strobes of the serial port front end
module page_memory_serial_port_monitor
  import spi_port_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       serial_out_lane1_o,
  input wire logic       serial_out_lane1_oe,
  input wire logic       serial_in_lane0_oe,
  input wire logic       protect_pin_lane2_oe,
  input wire logic       pause_pin_lane3_oe,
  input wire logic       rx_valid,
  input wire logic       cmd_start,
  input wire logic       cmd_exec,
  input wire logic       tx_req,
  input wire read_mode_t read_mode,
  input wire logic       write_in_progress,
  input wire logic       bp_wr_en,
  input wire logic [2:0] block_protect_bits,
  input wire logic       protect_lock,
  input wire logic       standby,
  input wire logic       active_power,
  input wire logic       paused
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence s_desel; cs_n [*8]; endsequence
  sequence s_idle; (cs_n && !write_in_progress) [*8]; endsequence
  sequence s_selected; cmd_start ##4 !cs_n; endsequence
  // ****************************************************************
  // checks
  // ****************************************************************
  AST_OUT_FLOAT: assert property (s_desel |-> !serial_out_lane1_oe)
    else $error("lane1 driven while deselected");
  AST_IN_FLOAT: assert property (s_desel |-> !serial_in_lane0_oe && !protect_pin_lane2_oe && !pause_pin_lane3_oe)
    else $error("input lane driven while deselected");
  AST_OUT_ON_FALL: assert property (serial_out_lane1_oe && $past(serial_out_lane1_oe)
    && $changed(serial_out_lane1_o) |-> !sclk)
    else $error("lane1 changed while clock high");
  AST_TX_ON_FALL: assert property (tx_req |-> !sclk && !cs_n)
    else $error("output load away from a falling edge");
  AST_RX_ON_RISE: assert property (rx_valid |-> sclk ##1 !rx_valid)
    else $error("byte strobe not a single pulse after a rise");
  AST_START: assert property (cmd_start |-> !cs_n)
    else $error("frame start without select low");
  AST_EXEC: assert property (cmd_exec |-> cs_n)
    else $error("execute without select high");
  AST_STANDBY: assert property (s_idle |-> standby && !active_power)
    else $error("no standby while deselected and idle");
  AST_ACTIVE: assert property (s_selected |-> active_power && !standby)
    else $error("not active while selected");
  AST_PAUSE_FLOAT: assert property (paused [*2] |-> !serial_out_lane1_oe)
    else $error("lane1 driven during pause");
  AST_LOCK: assert property (protect_lock && bp_wr_en |=> $stable(block_protect_bits))
    else $error("protect bits written while locked");
  AST_SINGLE: assert property ((read_mode == READ_SINGLE) [*8] |-> !serial_in_lane0_oe && !protect_pin_lane2_oe)
    else $error("extra lane driven in single mode");
  AST_QUAD: assert property (pause_pin_lane3_oe |-> protect_pin_lane2_oe && read_mode == READ_QUAD)
    else $error("lane3 driven without lane2");
endmodule

bind page_memory_serial_port page_memory_serial_port_monitor mon (.*);

// ---- testbench/spi_master_model.sv ----
// bus master model driving the link pins of the serial port
module spi_master_model (
  output logic            sclk,
  output logic            cs_n,
  output logic            mosi,
  output logic            wp_n,
  output logic            hold_n,
  input  wire logic [3:0] lanes
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOW = 62;
  localparam int HIGH = 63;
  logic cpol;
  // select starts low, so the first frame needs a fresh fall
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    wp_n = 1'b1;
    hold_n = 1'b1;
  end
  task automatic pins(input logic wp, input logic hold);
    wp_n = wp;
    hold_n = hold;
  endtask
  task automatic open_frame(input logic pol);
    cpol = pol;
    sclk = pol;
    #LOW cs_n = 1'b0;
    #HIGH;
  endtask
  task automatic bit_out(input logic b);
    sclk = 1'b0;
    mosi = b;
    #LOW sclk = 1'b1;
    #HIGH;
  endtask
  task automatic idle_low;
    sclk = 1'b0;
    #LOW;
  endtask
  task automatic byte_out(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
  endtask
  task automatic byte_in(input int nl, output logic [7:0] d);
    d = 8'h00;
    if (nl > 1) mosi = ~mosi;
    for (int i = 0; i < 8 / nl; i++) begin
      sclk = 1'b0;
      #LOW sclk = 1'b1;
      d = (nl == 1) ? {d[6:0], lanes[1]} : (nl == 2) ? {d[5:0], lanes[1:0]} : {d[3:0], lanes};
      #HIGH;
    end
  endtask
  task automatic close_frame;
    sclk = cpol;
    #LOW cs_n = 1'b1;
    mosi = ~mosi;
    #(4 * HIGH);
  endtask
endmodule

// ---- testbench/tb_page_memory_serial_port.sv ----
// self-checking bench for the serial port front end
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module tb_page_memory_serial_port
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, sclk, cs_n, mosi, wp_n, hold_n, read_cmd, write_in_progress, srwd, bp_wr_en, tb_wr_data;
  logic serial_out_lane1_o, serial_out_lane1_oe, serial_in_lane0_o, serial_in_lane0_oe, tx_req;
  logic protect_pin_lane2_o, protect_pin_lane2_oe, pause_pin_lane3_o, pause_pin_lane3_oe, rx_valid;
  logic rx_first, cmd_start, cmd_end, cmd_exec, iface_reset, top_bottom_select, protect_lock;
  logic standby, active_power, paused;
  logic [7:0] rx_byte, tx_byte, last_rx;
  logic [2:0] bp_wr_data, block_protect_bits;
  read_mode_t read_mode;
  int         n_errors, n_checks, n_rx, n_start, n_exec, n_reset, n_cyc, n_end;
  wire logic  serial_in_lane0_i = serial_in_lane0_oe ? serial_in_lane0_o : mosi;
  wire logic  protect_pin_lane2_i = protect_pin_lane2_oe ? protect_pin_lane2_o : wp_n;
  wire logic  pause_pin_lane3_i = pause_pin_lane3_oe ? pause_pin_lane3_o : hold_n;
  wire logic  lane1_w = serial_out_lane1_oe ? serial_out_lane1_o : ~serial_out_lane1_o;
  wire logic [3:0] lanes = {pause_pin_lane3_i, protect_pin_lane2_i, lane1_w, serial_in_lane0_i};

  page_memory_serial_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .serial_out_lane1_o(serial_out_lane1_o), .serial_out_lane1_oe(serial_out_lane1_oe),
    .serial_in_lane0_i(serial_in_lane0_i), .serial_in_lane0_o(serial_in_lane0_o),
    .serial_in_lane0_oe(serial_in_lane0_oe), .protect_pin_lane2_i(protect_pin_lane2_i),
    .protect_pin_lane2_o(protect_pin_lane2_o), .protect_pin_lane2_oe(protect_pin_lane2_oe),
    .pause_pin_lane3_i(pause_pin_lane3_i), .pause_pin_lane3_o(pause_pin_lane3_o),
    .pause_pin_lane3_oe(pause_pin_lane3_oe), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first),
    .cmd_start(cmd_start), .cmd_end(cmd_end), .cmd_exec(cmd_exec), .iface_reset(iface_reset),
    .read_cmd(read_cmd), .read_mode(read_mode), .tx_byte(tx_byte), .tx_req(tx_req),
    .write_in_progress(write_in_progress), .srwd(srwd), .bp_wr_en(bp_wr_en), .bp_wr_data(bp_wr_data),
    .tb_wr_data(tb_wr_data), .block_protect_bits(block_protect_bits), .top_bottom_select(top_bottom_select),
    .protect_lock(protect_lock), .standby(standby), .active_power(active_power), .paused(paused));
  spi_master_model m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n), .hold_n(hold_n), .lanes(lanes));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ****************************************************************
  // strobe counters and hang limit
  // ****************************************************************
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      n_rx++;
      last_rx = rx_byte;
    end
    if (cmd_start === 1'b1) n_start++;
    if (cmd_exec === 1'b1) n_exec++;
    if (iface_reset === 1'b1) n_reset++;
    if (cmd_end === 1'b1) n_end++;
  end
  always @(posedge clk_sys) begin
    n_cyc++;
    if (n_cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_ignore;
    m.byte_out(8'h9A);
    `CHK("bytes before select fall", 0, n_rx)
    `CHK("starts before select fall", 0, n_start)
    m.close_frame();
  endtask
  task automatic t_frames;
    int e;
    e = n_exec;
    m.open_frame(1'b0);
    m.byte_out(8'h02);
    m.byte_out(8'hB7);
    m.close_frame();
    `CHK("rx byte", 8'hB7, last_rx)
    `CHK("rx count", 2, n_rx)
    `CHK("exec count", e + 1, n_exec)
    `CHK("first flag", 1'b0, rx_first)
    m.open_frame(1'b1);
    m.byte_out(8'h4E);
    m.bit_out(1'b1);
    m.close_frame();
    `CHK("rx byte", 8'h4E, last_rx)
    `CHK("first flag", 1'b1, rx_first)
    `CHK("end count", 2, n_end)
    `CHK("exec count", e + 1, n_exec)
  endtask
  task automatic t_hold;
    int e, r;
    logic [7:0] v;
    e = n_exec;
    r = n_reset;
    v = 8'hC5;
    m.open_frame(1'b0);
    for (int i = 7; i > 3; i--) m.bit_out(v[i]);
    m.pins(1'b1, 1'b0);
    m.bit_out(1'b0);
    m.bit_out(1'b1);
    `CHK("paused", 1'b1, paused)
    m.idle_low();
    m.pins(1'b1, 1'b1);
    repeat (12) @(negedge clk_sys);
    `CHK("paused", 1'b0, paused)
    for (int i = 3; i >= 0; i--) m.bit_out(v[i]);
    m.close_frame();
    `CHK("held byte", v, last_rx)
    `CHK("exec count", e + 1, n_exec)
    m.open_frame(1'b0);
    m.bit_out(1'b1);
    m.pins(1'b1, 1'b0);
    m.idle_low();
    repeat (12) @(negedge clk_sys);
    `CHK("paused", 1'b1, paused)
    m.close_frame();
    `CHK("iface reset", r + 1, n_reset)
    `CHK("exec count", e + 1, n_exec)
    m.pins(1'b1, 1'b1);
  endtask
  task automatic t_read(input read_mode_t md, input int nl, input int nb, input logic pol, input logic [7:0] val);
    logic [7:0] got;
    int         base;
    @(negedge clk_sys);
    read_mode = md;
    tx_byte = val;
    base = n_rx;
    m.open_frame(pol);
    fork
      for (int i = 0; i < nb; i++) m.byte_out(8'h81);
      begin
        wait (n_rx == base + nb);
        @(negedge clk_sys);
        read_cmd = 1'b1;
      end
    join
    m.byte_in(nl, got);
    @(negedge clk_sys);
    read_cmd = 1'b0;
    m.close_frame();
    `CHK("read byte", val, got)
  endtask
  task automatic t_protect;
    m.pins(1'b0, 1'b1);
    @(negedge clk_sys);
    srwd = 1'b1;
    bp_wr_data = 3'h5;
    tb_wr_data = 1'b1;
    repeat (10) @(negedge clk_sys);
    bp_wr_en = 1'b1;
    @(negedge clk_sys);
    bp_wr_en = 1'b0;
    `CHK("lock", 1'b1, protect_lock)
    `CHK("protect bits", 3'h0, block_protect_bits)
    m.pins(1'b1, 1'b1);
    repeat (10) @(negedge clk_sys);
    bp_wr_en = 1'b1;
    @(negedge clk_sys);
    bp_wr_en = 1'b0;
    @(negedge clk_sys);
    `CHK("protect bits", 3'h5, block_protect_bits)
    `CHK("top bottom", 1'b1, top_bottom_select)
  endtask
  task automatic t_standby;
    write_in_progress = 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK("standby", 1'b0, standby)
    `CHK("active", 1'b1, active_power)
    write_in_progress = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK("standby", 1'b1, standby)
  endtask
  initial begin
    rst_n = 1'b0;
    read_cmd = 1'b0;
    read_mode = READ_SINGLE;
    tx_byte = 8'h00;
    write_in_progress = 1'b0;
    srwd = 1'b0;
    bp_wr_en = 1'b0;
    bp_wr_data = 3'h0;
    tb_wr_data = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    t_ignore();
    t_frames();
    t_hold();
    t_read(READ_SINGLE, 1, 1, 1'b0, 8'hA5);
    t_read(READ_SINGLE, 1, 1, 1'b1, 8'h5A);
    t_read(READ_DUAL, 2, 5, 1'b0, 8'hC3);
    t_read(READ_QUAD, 4, 5, 1'b1, 8'h96);
    t_protect();
    @(negedge clk_sys);
    t_standby();
    summarize();
  end
endmodule
